// file: ncpu_irq_pkg.sv
// Purpose: shared constants for the nibble cpu interrupt unit
// Assumes: 100 MHz clk, Avalon-MM slave with 32-bit wide register data
// Notes:   word offsets are byte addresses, one register per 32-bit word
package ncpu_irq_pkg;
  localparam int          NCPU_SRC_DEF   = 6;
  localparam int          NCPU_ADDR_W    = 6;
  localparam int          NCPU_VEC_W     = 12;
  localparam logic [5:0]  NCPU_OFS_FLAG0 = 6'h00;
  localparam logic [5:0]  NCPU_OFS_FLAG1 = 6'h04;
  localparam logic [5:0]  NCPU_OFS_MASK  = 6'h08;
  localparam logic [5:0]  NCPU_OFS_CTRL  = 6'h0c;
  localparam logic [5:0]  NCPU_OFS_STAT  = 6'h10;
  localparam logic [5:0]  NCPU_OFS_EN    = 6'h14;
  localparam logic [5:0]  NCPU_OFS_CLR   = 6'h18;
  localparam logic [5:0]  NCPU_OFS_INFO  = 6'h1c;
  localparam int          NCPU_IE_BIT    = 0;
  localparam int          NCPU_EV_ACCEPT = 0;
  localparam int          NCPU_EV_LOST   = 1;
  localparam int          NCPU_EV_W      = 2;
  localparam logic [11:0] NCPU_VEC_BASE  = 12'h102;
  localparam logic [11:0] NCPU_VEC_STEP  = 12'h002;
  localparam logic [31:0] NCPU_RST_WORD  = 32'h0000_0000;
  localparam int          NCPU_RD_WAIT   = 1;
  typedef enum logic [2:0] {
    NCPU_IDLE  = 3'b001,
    NCPU_TAKE  = 3'b010,
    NCPU_FETCH = 3'b100
  } ncpu_state_t;
endpackage

// file: ncpu_prio_enc.sv
// Purpose: fixed priority encoder, source 0 highest
// Assumes: one-hot or many-hot request vector
// Notes:   registered output
module ncpu_prio_enc #(
  parameter int N = 6,
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] req,
  output logic              any,
  output logic [W-1:0]      idx
);
  logic [W-1:0] next_idx;

  initial begin
    if (N < 1 || (1 << W) < N) $error("ncpu_prio_enc: bad width");
  end

  always_comb begin
    next_idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) next_idx = W'(i);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      any <= 1'b0;
      idx <= '0;
    end else begin
      any <= |req;
      idx <= next_idx;
    end
  end
endmodule

// file: ncpu_flag_bank.sv
// Purpose: interrupt factor flags with clear-on-read per register word
// Assumes: set events are one-cycle pulses from peripherals
// Notes:   set wins over the read-clear in the same cycle
module ncpu_flag_bank #(
  parameter int N = 6
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] set_ev,
  input  wire logic [N-1:0] mask,
  input  wire logic [N-1:0] gated,
  input  wire logic [N-1:0] rd_clr,
  output logic [N-1:0]      flag
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      wire allow = gated[g] ? mask[g] : 1'b1;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) flag[g] <= 1'b0;
        else if (set_ev[g] && allow) flag[g] <= 1'b1;
        else if (rd_clr[g]) flag[g] <= 1'b0;
      end
    end
  endgenerate
endmodule

// file: ncpu_irq_top.sv
// Contract
// - flag sets on event regardless of mask
// - input port flags set only when unmasked
// - accepting interrupt clears enable flag
// - re-enabled handler can be interrupted again
// - pending masked-in flag re-fires after enable
// - reading flag word clears those flags
// - one access clears every flag there
// - highest priority pending source gets vector
// - late higher request may change vector
//
// Purpose: interrupt unit for a 4-bit cpu core with Avalon-MM registers
// Assumes: event inputs synchronous to clk; core acks vector with vec_ack
// Notes:   sources 0..3 in flag word 0, rest in flag word 1
module ncpu_irq_top
  import ncpu_irq_pkg::*;
#(
  parameter int N_SRC = ncpu_irq_pkg::NCPU_SRC_DEF,
  parameter logic [N_SRC-1:0] GATED_SRC = 6'h30
) (
  input  wire logic                               clk,
  input  wire logic                               rst_n,
  input  wire logic [ncpu_irq_pkg::NCPU_ADDR_W-1:0] avs_address,
  input  wire logic                               avs_read,
  input  wire logic                               avs_write,
  input  wire logic [31:0]                        avs_writedata,
  output logic [31:0]                             avs_readdata,
  output logic                                    avs_waitrequest,
  input  wire logic [N_SRC-1:0]                   src_event,
  input  wire logic                               vec_ack,
  output logic                                    cpu_irq_req,
  output logic [ncpu_irq_pkg::NCPU_VEC_W-1:0]     cpu_vector,
  output logic                                    interrupts_on_state,
  output logic                                    irq
);
  import ncpu_irq_pkg::*;

  localparam int IW = (N_SRC > 1) ? $clog2(N_SRC) : 1;

  initial begin
    if (N_SRC < 1 || N_SRC > 8) $error("ncpu_irq_top: N_SRC must be 1..8");
  end

  function automatic logic hit(input logic [NCPU_ADDR_W-1:0] a,
                               input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [N_SRC-1:0]     mask;
  logic                 ie;
  logic [N_SRC-1:0]     flag;
  logic [N_SRC-1:0]     rd_clr;
  logic [NCPU_EV_W-1:0] ev_stat;
  logic [NCPU_EV_W-1:0] ev_en;
  logic                 acc_pend;
  ncpu_state_t          state;
  logic                 enc_any;
  logic [IW-1:0]        enc_idx;

  wire [7:0] flag8 = 8'(flag);
  wire [7:0] mask8 = 8'(mask);

  // bus decode
  wire wr_mask  = avs_write && hit(avs_address, NCPU_OFS_MASK);
  wire wr_ctrl  = avs_write && hit(avs_address, NCPU_OFS_CTRL);
  wire wr_en    = avs_write && hit(avs_address, NCPU_OFS_EN);
  wire wr_clr   = avs_write && hit(avs_address, NCPU_OFS_CLR);
  wire acc_new  = (avs_read || avs_write) && !acc_pend;
  // capture and clear on one edge, so no event slips in between
  wire rd_take  = avs_read && !acc_pend;
  wire rd_f0    = rd_take && hit(avs_address, NCPU_OFS_FLAG0);
  wire rd_f1    = rd_take && hit(avs_address, NCPU_OFS_FLAG1);

  // whole word clears, as a bit test would
  wire [7:0] clr8 = {{4{rd_f1}}, {4{rd_f0}}};

  wire [31:0] rd_mux =
      hit(avs_address, NCPU_OFS_FLAG0) ? {28'h0, flag8[3:0]} :
      hit(avs_address, NCPU_OFS_FLAG1) ? {28'h0, flag8[7:4]} :
      hit(avs_address, NCPU_OFS_MASK)  ? {24'h0, mask8} :
      hit(avs_address, NCPU_OFS_CTRL)  ? {31'h0, ie} :
      hit(avs_address, NCPU_OFS_STAT)  ? {30'h0, ev_stat} :
      hit(avs_address, NCPU_OFS_EN)    ? {30'h0, ev_en} :
      hit(avs_address, NCPU_OFS_INFO)  ? {24'h0, 8'(N_SRC)} :
      NCPU_RST_WORD;

  assign rd_clr = (N_SRC'(clr8));

  ncpu_flag_bank #(.N(N_SRC)) u_flags (
    .clk    (clk),
    .rst_n  (rst_n),
    .set_ev (src_event),
    .mask   (mask),
    .gated  (GATED_SRC),
    .rd_clr (rd_clr),
    .flag   (flag)
  );

  wire [N_SRC-1:0] active = flag & mask & {N_SRC{ie}};

  ncpu_prio_enc #(.N(N_SRC), .W(IW)) u_enc (
    .clk   (clk),
    .rst_n (rst_n),
    .req   (active),
    .any   (enc_any),
    .idx   (enc_idx)
  );

  // accept when encoder still agrees the enable is on
  wire accept   = (state == NCPU_IDLE) && enc_any && ie;
  wire [11:0] vec_sel = NCPU_VEC_BASE + 12'(NCPU_VEC_STEP * 12'(enc_idx));
  wire lost_req = (state != NCPU_IDLE) && |active;

  // bus slave: every access answers after one wait cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_pend        <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else begin
      acc_pend        <= acc_new;
      avs_waitrequest <= !acc_new;
      if (rd_take) avs_readdata <= rd_mux;
    end
  end

  // writes complete only while waitrequest is low
  wire wr_ok = !avs_waitrequest;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= '0;
      ie   <= 1'b0;
    end else begin
      if (wr_mask && wr_ok) mask <= avs_writedata[N_SRC-1:0];
      if (accept) ie <= 1'b0;
      else if (wr_ctrl && wr_ok) ie <= avs_writedata[NCPU_IE_BIT];
    end
  end

  // vector hand-off; a late higher source only alters the vector before fetch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= NCPU_IDLE;
      cpu_irq_req <= 1'b0;
      cpu_vector  <= '0;
    end else begin
      case (state)
        NCPU_IDLE: begin
          if (accept) begin
            state       <= NCPU_TAKE;
            cpu_irq_req <= 1'b1;
            cpu_vector  <= vec_sel;
          end
        end
        NCPU_TAKE: begin
          if (enc_any && !vec_ack) cpu_vector <= vec_sel;
          if (vec_ack) begin
            state       <= NCPU_FETCH;
            cpu_irq_req <= 1'b0;
          end
        end
        NCPU_FETCH: begin
          state <= NCPU_IDLE;
        end
        default: begin
          state       <= NCPU_IDLE;
          cpu_irq_req <= 1'b0;
        end
      endcase
    end
  end

  // event status, enable and write-one-to-clear; set wins
  wire [NCPU_EV_W-1:0] ev_set = {lost_req, accept};
  wire [NCPU_EV_W-1:0] ev_clr = (wr_clr && wr_ok) ? avs_writedata[NCPU_EV_W-1:0] : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_stat <= '0;
      ev_en   <= '0;
      irq     <= 1'b0;
    end else begin
      ev_stat <= ev_set | (ev_stat & ~ev_clr);
      if (wr_en && wr_ok) ev_en <= avs_writedata[NCPU_EV_W-1:0];
      irq     <= |(ev_stat & ev_en);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) interrupts_on_state <= 1'b0;
    else interrupts_on_state <= ie;
  end
endmodule

// file: ncpu_irq_checker.sv
// Purpose: port-level checks for the nibble cpu interrupt unit
// Assumes: one clock, async active-low reset
// Notes:   bound to the top module below
module ncpu_irq_checker
  import ncpu_irq_pkg::*;
#(
  parameter int N_SRC = 6
) (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic [NCPU_ADDR_W-1:0] avs_address,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic                   avs_waitrequest,
  input wire logic                   vec_ack,
  input wire logic                   cpu_irq_req,
  input wire logic [NCPU_VEC_W-1:0]  cpu_vector,
  input wire logic                   interrupts_on_state
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] VMAX = NCPU_VEC_BASE + 12'(2 * (N_SRC - 1));
  wire ctrl_wr = avs_write && !avs_waitrequest && avs_address == NCPU_OFS_CTRL;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rst; !$past(rst_n) |-> !cpu_irq_req && !interrupts_on_state; endproperty
  property p_gate; $rose(cpu_irq_req) |-> $past(interrupts_on_state); endproperty
  property p_take; $rose(cpu_irq_req) |=> !interrupts_on_state; endproperty
  property p_off;
    !interrupts_on_state && !$past(ctrl_wr) |=> !interrupts_on_state;
  endproperty
  property p_on;
    ctrl_wr && avs_writedata[NCPU_IE_BIT] && !interrupts_on_state |-> ##2 interrupts_on_state;
  endproperty
  property p_vec; cpu_irq_req |-> !cpu_vector[0] && cpu_vector inside {[NCPU_VEC_BASE:VMAX]};
  endproperty
  property p_hold; cpu_irq_req && !vec_ack |=> cpu_irq_req; endproperty
  property p_ack; cpu_irq_req && vec_ack |=> !cpu_irq_req; endproperty
  a_rst: assert property (p_rst) else $error("req or enable after reset");
  a_gate: assert property (p_gate) else $error("request while disabled");
  a_take: assert property (p_take) else $error("enable kept on accept");
  a_off: assert property (p_off) else $error("enable rose by itself");
  a_on: assert property (p_on) else $error("enable write lost");
  a_vec: assert property (p_vec) else $error("vector out of set");
  a_hold: assert property (p_hold) else $error("request dropped early");
  a_ack: assert property (p_ack) else $error("request kept after fetch");
  c_req: cover property ($rose(cpu_irq_req));
  c_ack: cover property (vec_ack);
  c_on: cover property (ctrl_wr);
endmodule
bind ncpu_irq_top ncpu_irq_checker #(.N_SRC(N_SRC)) u_ncpu_irq_checker (.clk(clk),
  .rst_n(rst_n), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .vec_ack(vec_ack),
  .cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector),
  .interrupts_on_state(interrupts_on_state));

// file: ncpu_core_model.sv
// Purpose: cpu core stand-in that fetches vectors
// Assumes: fetch delay 1 or 4 cycles as slow selects
// Notes:   records each fetched vector
module ncpu_core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cpu_irq_req,
  input  wire logic        slow,
  input  wire logic [11:0] cpu_vector,
  output logic             vec_ack,
  output logic [11:0]      got_vec,
  output int               got_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] dly;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_ack <= 1'b0;
      dly     <= 3'h0;
      got_vec <= 12'h000;
      got_n   <= 0;
    end else if (vec_ack) begin
      vec_ack <= 1'b0;
    end else if (cpu_irq_req) begin
      dly <= dly + 3'h1;
      if (dly == (slow ? 3'h3 : 3'h0)) begin
        vec_ack <= 1'b1;
        got_vec <= cpu_vector;
        got_n   <= got_n + 1;
        dly     <= 3'h0;
      end
    end
  end
endmodule

// file: testbench.sv
// Purpose: self-checking bench for the nibble cpu interrupt unit
// Assumes: bench plays handler software, model plays the core
// Notes:   random source sets from a fixed seed
module testbench;
  import ncpu_irq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, slow = 0;
  logic [5:0] avs_address = '0, src_event = '0, p;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic avs_waitrequest, vec_ack, cpu_irq_req, interrupts_on_state, irq;
  logic [11:0] cpu_vector, got_vec;
  int got_n, err_total = 0, check_count = 0, cyc = 0, seed = 32'hc595, n0;
  ncpu_irq_top u_ncpu_irq_top (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_event(src_event),
    .vec_ack(vec_ack), .cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector),
    .interrupts_on_state(interrupts_on_state), .irq(irq));
  ncpu_core_model u_ncpu_core_model (.clk(clk), .rst_n(rst_n), .cpu_irq_req(cpu_irq_req),
    .slow(slow), .cpu_vector(cpu_vector), .vec_ack(vec_ack), .got_vec(got_vec),
    .got_n(got_n));
  initial forever #5 clk = ~clk;
  task automatic close_out;
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic acc(input int n);
    for (int k = 0; k < 40 && got_n == n; k++) @(posedge clk);
    chk("accept", got_n != n, 1);
  endtask
  function automatic logic [11:0] exp_vec(input logic [5:0] s);
    for (int i = 5; i >= 0; i--) if (s[i]) exp_vec = 12'h102 + 12'(2 * i);
  endfunction
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk("req", cpu_irq_req, 0);
    for (int a = 0; a < 16; a += 4) begin
      bus(0, 6'(a), 0);
      chk("reg", q, 0);
    end
    @(posedge clk) src_event <= 6'h3f;
    @(posedge clk) src_event <= 6'h00;
    bus(1, NCPU_OFS_CTRL, 32'h1);
    repeat (6) @(posedge clk);
    chk("masked", cpu_irq_req, 0);
    chk("onstate", interrupts_on_state, 1);
    bus(1, NCPU_OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    bus(0, NCPU_OFS_FLAG0, 0);
    chk("flag0", q, 32'hf);
    bus(0, NCPU_OFS_FLAG1, 0);
    chk("flag1", q, 0);
    bus(0, NCPU_OFS_FLAG0, 0);
    chk("rdclr", q, 0);
    bus(1, 6'h3c, 32'hf);
    bus(0, 6'h3c, 0);
    chk("unmapped", q, 0);
    bus(0, NCPU_OFS_INFO, 0);
    chk("info", q, 32'(NCPU_SRC_DEF));
    bus(1, NCPU_OFS_MASK, 32'h3f);
    for (int it = 0; it < 16; it++) begin
      p = 6'($random(seed));
      if (p == 6'h00) p = 6'h20;
      slow <= it[0];
      @(posedge clk) src_event <= p;
      @(posedge clk) src_event <= 6'h00;
      repeat (4) @(posedge clk);
      chk("idle", cpu_irq_req, 0);
      n0 = got_n;
      bus(1, NCPU_OFS_CTRL, 32'h1);
      acc(n0);
      chk("vector", got_vec, exp_vec(p));
      chk("enable", interrupts_on_state, 0);
      if (!it[0]) begin
        n0 = got_n;
        bus(1, NCPU_OFS_CTRL, 32'h1);
        acc(n0);
        chk("refire", got_vec, exp_vec(p));
      end
      bus(0, NCPU_OFS_FLAG0, 0);
      chk("flag0", q, {28'h0, p[3:0]});
      bus(0, NCPU_OFS_FLAG1, 0);
      chk("flag1", q, {30'h0, p[5:4]});
      bus(0, NCPU_OFS_FLAG0, 0);
      chk("wordclr", q, 0);
    end
    bus(0, NCPU_OFS_STAT, 0);
    chk("stat", q, 32'h1);
    chk("irqoff", irq, 0);
    bus(1, NCPU_OFS_EN, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", irq, 1);
    bus(1, NCPU_OFS_CLR, 32'h3);
    repeat (2) @(posedge clk);
    chk("irqclr", irq, 0);
    bus(0, NCPU_OFS_STAT, 0);
    chk("statclr", q, 0);
    close_out;
  end
endmodule
